// file: verilog/bdm_pkg.sv
// constants for the banked data memory and peripheral flag block
// assumes one core clock and an 8-bit core data path
package bdm_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int BDM_ADDR_W = 7;
   localparam int BDM_DATA_W = 8;
   localparam int BDM_BANKS = 4;
   localparam logic [6:0] BDM_SFR_TOP = 7'h1F;
   localparam logic [6:0] BDM_GPR_BASE = 7'h20;
   localparam logic [6:0] BDM_BANK_TOP = 7'h7F;
   localparam int BDM_GPR_PER_BANK = 96;
   // ----------------------------------------
   // offsets
   // ----------------------------------------
   localparam logic [6:0] BDM_OFS_INDIRECT = 7'h00;
   localparam logic [6:0] BDM_OFS_STATUS = 7'h03;
   localparam logic [6:0] BDM_OFS_POINTER = 7'h04;
   localparam logic [6:0] BDM_OFS_FLAGS = 7'h0C;
   // ----------------------------------------
   // fields
   // ----------------------------------------
   localparam int BDM_ST_IND_BANK = 7;
   localparam int BDM_ST_BANK_HI = 6;
   localparam int BDM_ST_BANK_LO = 5;
   localparam logic [7:0] BDM_ST_MASK = 8'hE0;
   localparam int BDM_F_PARALLEL = 7;
   localparam int BDM_F_CONVERTER = 6;
   localparam int BDM_F_RECEIVE = 5;
   localparam int BDM_F_TRANSMIT = 4;
   localparam int BDM_F_SYNC = 3;
   localparam int BDM_F_CAPTURE = 2;
   localparam int BDM_F_TIMER2 = 1;
   localparam int BDM_F_TIMER1 = 0;
   localparam logic [7:0] BDM_F_RW_MASK = 8'hCF;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] BDM_STATUS_RST = 8'h00;
   localparam logic [7:0] BDM_POINTER_RST = 8'h00;
   localparam logic [7:0] BDM_FLAGS_RST = 8'h00;
endpackage

// file: verilog/bdm_data_memory.sv
// banked data memory with status, pointer and peripheral flag registers
// assumes the core issues at most one access per cycle, synchronous to clk
//
// What this block does
// - status bits 6 and 5 pick one of four banks, 00 to 11
// - each bank spans 128 bytes, offsets 00h to 7Fh
// - lowest offsets of every bank decode to special registers, not RAM
// - offsets above the special region are read/write static RAM
// - status and pointer answer at the same offset in every bank
// - access direct by instruction address or indirect through the pointer
// - flags set on their event regardless of any enable bit
// - flag register holds eight flags, receive and transmit read-only, reset 0
// - parallel port flag set on host access, held until software clears
`timescale 1ns/1ps
`default_nettype none
module bdm_data_memory
   import bdm_pkg::*;
#(
   parameter int GPR_PER_BANK = BDM_GPR_PER_BANK
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // core access
   input wire logic [6:0] addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // bank state seen by the core
   output logic bank_select_hi,
   output logic bank_select_lo,
   output logic [7:0] indirect_address_pointer,
   // peripheral events, one-cycle pulses
   input wire logic parallel_access_done,
   input wire logic conversion_done,
   input wire logic sync_serial_event,
   input wire logic capture_compare_event,
   input wire logic timer2_match,
   input wire logic timer1_overflow,
   // peripheral levels
   input wire logic receive_buffer_full,
   input wire logic transmit_buffer_empty,
   // flag register contents
   output logic [7:0] peripheral_interrupt_flags_1
);
   // ----------------------------------------
   // address resolution
   // ----------------------------------------
   logic [7:0] status;
   logic [1:0] eff_bank;
   logic [6:0] eff_ofs;
   logic [8:0] ram_idx;
   logic is_gpr;
   logic [7:0] ram [BDM_BANKS*GPR_PER_BANK];

   function automatic logic [8:0] gpr_index(input logic [1:0] bank, input logic [6:0] ofs);
      logic [8:0] rel;
      rel = {2'b00, ofs - BDM_GPR_BASE};
      return 9'(bank * GPR_PER_BANK) + rel;
   endfunction

   always_comb begin
      if (addr == BDM_OFS_INDIRECT) begin
         eff_bank = {status[BDM_ST_IND_BANK], indirect_address_pointer[7]};
         eff_ofs = indirect_address_pointer[6:0];
      end else begin
         eff_bank = {status[BDM_ST_BANK_HI], status[BDM_ST_BANK_LO]};
         eff_ofs = addr;
      end
      is_gpr = (eff_ofs >= BDM_GPR_BASE) && (eff_ofs <= BDM_BANK_TOP);
      ram_idx = gpr_index(eff_bank, eff_ofs);
   end

   // ----------------------------------------
   // special registers
   // ----------------------------------------
   logic [7:0] next_status;
   logic [7:0] next_pointer;
   logic [7:0] next_flags;
   logic [7:0] flag_sets;
   logic wr_sfr;

   always_comb begin
      wr_sfr = wr_en && !is_gpr;
      next_status = status;
      next_pointer = indirect_address_pointer;
      next_flags = peripheral_interrupt_flags_1;
      if (wr_sfr && eff_ofs == BDM_OFS_STATUS) begin
         next_status = wr_data & BDM_ST_MASK;
      end
      if (wr_sfr && eff_ofs == BDM_OFS_POINTER) begin
         next_pointer = wr_data;
      end
      if (wr_sfr && eff_ofs == BDM_OFS_FLAGS && eff_bank == 2'b00) begin
         next_flags = (wr_data & BDM_F_RW_MASK) | (next_flags & ~BDM_F_RW_MASK);
      end
      flag_sets = 8'h00;
      flag_sets[BDM_F_PARALLEL] = parallel_access_done;
      flag_sets[BDM_F_CONVERTER] = conversion_done;
      flag_sets[BDM_F_SYNC] = sync_serial_event;
      flag_sets[BDM_F_CAPTURE] = capture_compare_event;
      flag_sets[BDM_F_TIMER2] = timer2_match;
      flag_sets[BDM_F_TIMER1] = timer1_overflow;
      next_flags = next_flags | flag_sets;
      next_flags[BDM_F_RECEIVE] = receive_buffer_full;
      next_flags[BDM_F_TRANSMIT] = transmit_buffer_empty;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status <= BDM_STATUS_RST;
         indirect_address_pointer <= BDM_POINTER_RST;
         peripheral_interrupt_flags_1 <= BDM_FLAGS_RST;
      end else begin
         status <= next_status;
         indirect_address_pointer <= next_pointer;
         peripheral_interrupt_flags_1 <= next_flags;
      end
   end

   assign bank_select_hi = status[BDM_ST_BANK_HI];
   assign bank_select_lo = status[BDM_ST_BANK_LO];

   // ----------------------------------------
   // general purpose ram
   // ----------------------------------------
   // static ram above special region
   always_ff @(posedge clk) begin
      if (wr_en && is_gpr) begin
         ram[ram_idx] <= wr_data;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   logic [7:0] rd_mux;
   logic [7:0] next_rd_data;

   always_comb begin
      rd_mux = 8'h00;
      if (is_gpr) begin
         rd_mux = ram[ram_idx];
      end else if (eff_ofs == BDM_OFS_STATUS) begin
         rd_mux = status;
      end else if (eff_ofs == BDM_OFS_POINTER) begin
         rd_mux = indirect_address_pointer;
      end else if (eff_ofs == BDM_OFS_FLAGS && eff_bank == 2'b00) begin
         rd_mux = peripheral_interrupt_flags_1;
      end
      next_rd_data = rd_en ? rd_mux : rd_data;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_data <= next_rd_data;
         rd_valid <= rd_en;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic [6:0] prev_addr;
   logic [7:0] prev_wdata;
   logic prev_gpr_wr;
   logic [7:0] prev_status;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_addr <= 7'h00;
         prev_wdata <= 8'h00;
         prev_gpr_wr <= 1'b0;
         prev_status <= 8'h00;
      end else if (wr_en) begin
         prev_addr <= addr;
         prev_wdata <= wr_data;
         prev_gpr_wr <= is_gpr && addr != BDM_OFS_INDIRECT;
         prev_status <= status;
      end
   end

   sequence s_status_write;
      wr_en && addr == BDM_OFS_STATUS;
   endsequence

   property p_bank_select;
      @(posedge clk) disable iff (!rstn)
      s_status_write |=> {bank_select_hi, bank_select_lo} == $past(wr_data[6:5]);
   endproperty
   a_bank_select: assert property (p_bank_select) else $error("bank select not taken");

   sequence s_ram_write_then_read;
      prev_gpr_wr && rd_en && addr == prev_addr && !wr_en && status == prev_status;
   endsequence

   property p_ram_roundtrip;
      @(posedge clk) disable iff (!rstn)
      s_ram_write_then_read |=> rd_data == $past(prev_wdata);
   endproperty
   a_ram_roundtrip: assert property (p_ram_roundtrip) else $error("ram readback wrong");

   property p_sfr_gap;
      @(posedge clk) disable iff (!rstn)
      rd_en && addr == 7'h10 |=> rd_data == 8'h00;
   endproperty
   a_sfr_gap: assert property (p_sfr_gap) else $error("unused special slot not zero");

   property p_mirror;
      @(posedge clk) disable iff (!rstn)
      rd_en && addr == BDM_OFS_STATUS |=> rd_data == $past(status);
   endproperty
   a_mirror: assert property (p_mirror) else $error("status mirror wrong");

   property p_indirect;
      @(posedge clk) disable iff (!rstn)
      rd_en && addr == BDM_OFS_INDIRECT && indirect_address_pointer[6:0] == BDM_OFS_POINTER
         |=> rd_data == $past(indirect_address_pointer);
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect read wrong");

   sequence s_flag_clear;
      wr_en && addr == BDM_OFS_FLAGS && status[6:5] == 2'b00 && !wr_data[BDM_F_TIMER1];
   endsequence
   property p_set_wins;
      @(posedge clk) disable iff (!rstn)
      timer1_overflow ##0 s_flag_clear |=> peripheral_interrupt_flags_1[BDM_F_TIMER1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

   property p_parallel_hold;
      @(posedge clk) disable iff (!rstn)
      parallel_access_done ##1 !wr_en [*2] |=> peripheral_interrupt_flags_1[BDM_F_PARALLEL];
   endproperty
   a_parallel_hold: assert property (p_parallel_hold) else $error("parallel flag lost");

   property p_converter;
      @(posedge clk) disable iff (!rstn)
      !conversion_done && !wr_en && !peripheral_interrupt_flags_1[BDM_F_CONVERTER]
         |=> !peripheral_interrupt_flags_1[BDM_F_CONVERTER];
   endproperty
   a_converter: assert property (p_converter) else $error("converter flag rose early");

   property p_event_sets;
      @(posedge clk) disable iff (!rstn)
      capture_compare_event |=> peripheral_interrupt_flags_1[BDM_F_CAPTURE];
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event flag not set");

   property p_readonly;
      @(posedge clk) disable iff (!rstn)
      1'b1 |=> peripheral_interrupt_flags_1[BDM_F_RECEIVE] == $past(receive_buffer_full);
   endproperty
   a_readonly: assert property (p_readonly) else $error("receive flag not following");
endmodule // bdm_data_memory
`default_nettype wire

// file: testbench/bdm_core_model.sv
// core model: issues single-byte reads and writes
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module bdm_core_model (
   // clock
   input wire logic clk,
   // access lines
   output logic [6:0] addr,
   output logic rd_en,
   output logic wr_en,
   output logic [7:0] wr_data,
   // answer
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   initial begin
      addr = 7'h00;
      rd_en = 1'b0;
      wr_en = 1'b0;
      wr_data = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      addr = ~a;
      wr_data = ~d;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      addr = ~a;
      ok = rd_valid;
      d = rd_data;
   endtask
endmodule // bdm_core_model
`default_nettype wire

// file: testbench/tb.sv
// testbench for the banked data memory block
// assumes the core model drives every access
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bdm_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [6:0] addr;
   logic rd_en, wr_en, rd_valid, bhi, blo, ok;
   logic [7:0] wr_data, rd_data, ptr, flags, d;
   logic [5:0] ev = 6'h00;
   logic rx_full = 1'b0;
   logic tx_empty = 1'b1;
   int n_errors = 0;
   int n_compared = 0;
   always #50 clk = ~clk;
   bdm_core_model core (.clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
   bdm_data_memory uut (.clk(clk), .rstn(rstn), .addr(addr), .rd_en(rd_en),
      .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
      .bank_select_hi(bhi), .bank_select_lo(blo), .indirect_address_pointer(ptr),
      .parallel_access_done(ev[5]), .conversion_done(ev[4]),
      .sync_serial_event(ev[3]), .capture_compare_event(ev[2]),
      .timer2_match(ev[1]), .timer1_overflow(ev[0]),
      .receive_buffer_full(rx_full), .transmit_buffer_empty(tx_empty),
      .peripheral_interrupt_flags_1(flags));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      core.rd(a, d, ok);
      chk("rd_valid", 8'h01, {7'h00, ok});
      chk("rd_data", e, d);
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic t_banks;
      for (int b = 0; b < 4; b++) begin
         core.wr(7'h03, 8'(b << 5));
         chk("bank", 8'(b), {6'h00, bhi, blo});
         core.wr(7'h7F, 8'h10 + 8'(b));
      end
      rchk(7'h7F, 8'h13);
      for (int b = 0; b < 4; b++) begin
         core.wr(7'h03, 8'(b << 5));
         rchk(7'h7F, 8'h10 + 8'(b));
      end
      $display("banks done");
   endtask
   task automatic t_special;
      core.wr(7'h03, 8'h00);
      core.wr(7'h01, 8'hFF);
      rchk(7'h01, 8'h00);
      core.wr(7'h04, 8'hFF);
      core.wr(7'h03, 8'h60);
      rchk(7'h04, 8'hFF);
      rchk(7'h03, 8'h60);
      rchk(7'h10, 8'h00);
      chk("pointer", 8'hFF, ptr);
      rchk(7'h00, 8'h11);
      core.wr(7'h04, 8'h04);
      rchk(7'h00, 8'h04);
      $display("special done");
   endtask
   task automatic t_flags;
      core.wr(7'h03, 8'h00);
      chk("flags idle", 8'h10, flags);
      @(posedge clk);
      #1;
      ev = 6'h3F;
      @(posedge clk);
      #1;
      ev = 6'h00;
      chk("flags set", 8'hDF, flags);
      rx_full = 1'b1;
      @(posedge clk);
      #1;
      chk("flags rx", 8'hFF, flags);
      core.wr(7'h0C, 8'h00);
      chk("flags clr", 8'h30, flags);
      fork
         core.wr(7'h0C, 8'h00);
         begin
            @(posedge clk);
            #1;
            ev[0] = 1'b1;
            @(posedge clk);
            #1;
            ev[0] = 1'b0;
         end
      join
      rchk(7'h0C, 8'h31);
      core.wr(7'h0C, 8'h0F);
      rchk(7'h0C, 8'h3F);
      $display("flags done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      chk("flags rst", 8'h00, flags);
      chk("ptr rst", 8'h00, ptr);
      #1;
      rstn = 1'b1;
      t_banks();
      t_special();
      t_flags();
      close_out();
   end
   initial begin
      repeat (600) @(posedge clk);
      n_errors++;
      close_out();
   end
endmodule // tb
`default_nettype wire
